// *** src/cdcs_status_bank.sv ***
// Converter status register, channel 3 divider register and interrupt logic
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
// Functional notes
// - Channel 3 divider is 10 bits at 9:0, resets zero; reference = clock/setting.
// - Status 15:14 report the channel that raised the current flag or error.
// - Latched errors hold until status or error channel's result is read.
// - Status bit 11 marks a watchdog timeout since the last status read.
// - Status bit 10 marks an amplitude-high warning since the last status read.
// - Status bit 9 marks an amplitude-low warning since the last status read.
// - Status bit 6 sets when a new result is ready, only while ready routing is enabled.
// - In sequential mode ready sets only once every active channel converted.
// - Status bits 3 to 0 flag unread results of channels 0 to 3.
// - Channel 2 and 3 fields and divider exist only on four-channel builds.
// - Status fields are read-only and all read zero after reset.
// - Without sequential mode the select field picks the single converting channel.
// - With ready routing enabled, ready drives the low interrupt pin and status.
module cdcs_status_bank #(
    parameter int NUM_CHAN = 4
) (
    input  wire logic                          clk,
    input  wire logic                          srst,
    input  wire logic [cdcs_pkg::ADDR_W-1:0]   regAddr,
    input  wire logic [cdcs_pkg::DATA_W-1:0]   regWrData,
    input  wire logic                          regWrEn,
    input  wire logic                          regRdEn,
    output logic      [cdcs_pkg::DATA_W-1:0]   regRdData,
    input  wire logic                          sequenceModeEnable,
    input  wire logic [cdcs_pkg::CHAN_W-1:0]   singleChannelSelect,
    input  wire logic [cdcs_pkg::MAX_CHAN-1:0] activeChanMask,
    input  wire logic                          readyToIrqEnable,
    input  wire logic                          convDone,
    input  wire logic [cdcs_pkg::CHAN_W-1:0]   convChan,
    input  wire logic                          wdEvent,
    input  wire logic                          ahEvent,
    input  wire logic                          alEvent,
    input  wire logic [cdcs_pkg::CHAN_W-1:0]   eventChan,
    input  wire logic                          resultRead,
    input  wire logic [cdcs_pkg::CHAN_W-1:0]   resultReadChan,
    output logic      [cdcs_pkg::DIV_W-1:0]    refDividerChan3,
    output logic      [cdcs_pkg::FSEL_W-1:0]   sensorFreqSelectChan3,
    output logic                               refTickChan3,
    output logic                               irqOut,
    output logic                               irqPinN
);
    localparam logic FOUR_CHAN = (NUM_CHAN == cdcs_pkg::MAX_CHAN);

    function automatic logic chanValid(input logic [cdcs_pkg::CHAN_W-1:0] ch);
        chanValid = (int'(ch) < NUM_CHAN);
    endfunction

    function automatic logic [cdcs_pkg::MAX_CHAN-1:0] chanBit(
        input logic [cdcs_pkg::CHAN_W-1:0] ch);
        chanBit = chanValid(ch) ? (4'h1 << ch) : 4'h0;
    endfunction

    // Register bank state
    logic [cdcs_pkg::DIV_W-1:0]    divQ;
    logic [cdcs_pkg::DIV_W-1:0]    divD;
    logic [cdcs_pkg::FSEL_W-1:0]   fselQ;
    logic [cdcs_pkg::FSEL_W-1:0]   fselD;
    logic [cdcs_pkg::IRQ_W-1:0]    maskQ;
    logic [cdcs_pkg::IRQ_W-1:0]    maskD;
    logic [cdcs_pkg::DATA_W-1:0]   rdDataQ;
    logic [cdcs_pkg::DATA_W-1:0]   rdDataD;

    // Status state
    logic [cdcs_pkg::CHAN_W-1:0]   errChanQ;
    logic [cdcs_pkg::CHAN_W-1:0]   errChanD;
    logic                          wdFlagQ;
    logic                          wdFlagD;
    logic                          ahFlagQ;
    logic                          ahFlagD;
    logic                          alFlagQ;
    logic                          alFlagD;
    logic                          readyQ;
    logic                          readyD;
    logic [cdcs_pkg::MAX_CHAN-1:0] unreadQ;
    logic [cdcs_pkg::MAX_CHAN-1:0] unreadD;
    logic [cdcs_pkg::MAX_CHAN-1:0] seenQ;
    logic [cdcs_pkg::MAX_CHAN-1:0] seenD;
    logic [cdcs_pkg::IRQ_W-1:0]    irqStQ;
    logic [cdcs_pkg::IRQ_W-1:0]    irqStD;
    logic                          irqQ;
    logic                          irqD;
    logic                          irqPinNQ;
    logic                          irqPinND;

    // Decoded strobes and helpers
    logic                          statusRead;
    logic                          irqStRead;
    logic                          errClear;
    logic                          anyErr;
    logic                          convOk;
    logic                          readySet;
    logic                          seqComplete;
    logic [cdcs_pkg::MAX_CHAN-1:0] activeEff;
    logic [cdcs_pkg::MAX_CHAN-1:0] seenNext;
    logic [cdcs_pkg::DATA_W-1:0]   statusVal;

    cdcs_div_if divLink ();

    cdcs_ref_divider uRefDiv (
        .clk  (clk),
        .srst (srst),
        .dv   (divLink.gen)
    );

    assign divLink.divisor = divQ;

    assign statusRead = regRdEn && (regAddr == cdcs_pkg::ADDR_STATUS);
    assign irqStRead = regRdEn && (regAddr == cdcs_pkg::ADDR_IRQ_STATUS);
    // Result read of the reported channel also releases the error latch
    assign errClear = statusRead || (resultRead && (resultReadChan == errChanQ));
    assign anyErr = (wdEvent || ahEvent || alEvent) && chanValid(eventChan);
    assign convOk = convDone && chanValid(convChan);
    assign activeEff = activeChanMask & (FOUR_CHAN ? 4'hf : 4'h3);
    assign seenNext = seenQ | (convOk ? chanBit(convChan) : 4'h0);
    assign seqComplete = (activeEff != 4'h0) && ((seenNext & activeEff) == activeEff);

    always_comb begin
        if (sequenceModeEnable) begin
            readySet = convOk && (activeEff & chanBit(convChan)) != 4'h0 && seqComplete;
        end else begin
            readySet = convOk && (convChan == singleChannelSelect);
        end
    end

    // Status word as software sees it; reserved bits stay zero
    always_comb begin
        statusVal = cdcs_pkg::STATUS_RST;
        statusVal[cdcs_pkg::ST_ERRCH_MSB:cdcs_pkg::ST_ERRCH_LSB] = errChanQ;
        statusVal[cdcs_pkg::ST_WD] = wdFlagQ;
        statusVal[cdcs_pkg::ST_AH] = ahFlagQ;
        statusVal[cdcs_pkg::ST_AL] = alFlagQ;
        statusVal[cdcs_pkg::ST_RDY] = readyQ;
        for (int i = 0; i < cdcs_pkg::MAX_CHAN; i++) begin
            statusVal[cdcs_pkg::ST_UNREAD_TOP - i] = unreadQ[i];
        end
    end

    // Register bank next state and read path
    always_comb begin
        divD = divQ;
        fselD = fselQ;
        maskD = maskQ;
        rdDataD = cdcs_pkg::STATUS_RST;
        if (regWrEn && FOUR_CHAN && regAddr == cdcs_pkg::ADDR_DIV_CH3) begin
            // Reserved bits are dropped, so they always read back zero
            divD = regWrData[cdcs_pkg::DIV_MSB:cdcs_pkg::DIV_LSB];
            fselD = regWrData[cdcs_pkg::FSEL_MSB:cdcs_pkg::FSEL_LSB];
        end
        if (regWrEn && regAddr == cdcs_pkg::ADDR_IRQ_MASK) begin
            maskD = regWrData[cdcs_pkg::IRQ_W-1:0];
        end
        if (regRdEn) begin
            unique case (regAddr)
                cdcs_pkg::ADDR_DIV_CH3: begin
                    if (FOUR_CHAN) begin
                        rdDataD[cdcs_pkg::DIV_MSB:cdcs_pkg::DIV_LSB] = divQ;
                        rdDataD[cdcs_pkg::FSEL_MSB:cdcs_pkg::FSEL_LSB] = fselQ;
                    end
                end
                cdcs_pkg::ADDR_STATUS: begin
                    rdDataD = statusVal;
                end
                cdcs_pkg::ADDR_IRQ_STATUS: begin
                    rdDataD[cdcs_pkg::IRQ_W-1:0] = irqStQ;
                end
                cdcs_pkg::ADDR_IRQ_MASK: begin
                    rdDataD[cdcs_pkg::IRQ_W-1:0] = maskQ;
                end
                default: begin
                    rdDataD = cdcs_pkg::STATUS_RST;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            divQ <= cdcs_pkg::DIV_RST;
            fselQ <= cdcs_pkg::FSEL_RST;
            maskQ <= cdcs_pkg::MASK_RST;
            rdDataQ <= cdcs_pkg::STATUS_RST;
        end else begin
            divQ <= divD;
            fselQ <= fselD;
            maskQ <= maskD;
            rdDataQ <= rdDataD;
        end
    end

    // Status next state: a new event always beats a same-cycle clear
    always_comb begin
        errChanD = errChanQ;
        wdFlagD = wdFlagQ;
        ahFlagD = ahFlagQ;
        alFlagD = alFlagQ;
        if (errClear) begin
            errChanD = '0;
            wdFlagD = 1'b0;
            ahFlagD = 1'b0;
            alFlagD = 1'b0;
        end
        if (anyErr) begin
            errChanD = eventChan;
            wdFlagD = wdFlagD || wdEvent;
            ahFlagD = ahFlagD || ahEvent;
            alFlagD = alFlagD || alEvent;
        end
        readyD = readyQ;
        if (statusRead) begin
            readyD = 1'b0;
        end
        // Ready only reaches status while routing to the pin is on
        if (readySet && readyToIrqEnable) begin
            readyD = 1'b1;
        end
        seenD = seenQ;
        if (!sequenceModeEnable) begin
            seenD = 4'h0;
        end else if (convOk) begin
            seenD = seqComplete ? 4'h0 : seenNext;
        end
        unreadD = unreadQ;
        if (resultRead) begin
            unreadD = unreadD & ~chanBit(resultReadChan);
        end
        if (convOk) begin
            unreadD = unreadD | chanBit(convChan);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            errChanQ <= '0;
            wdFlagQ <= 1'b0;
            ahFlagQ <= 1'b0;
            alFlagQ <= 1'b0;
            readyQ <= 1'b0;
            seenQ <= 4'h0;
            unreadQ <= 4'h0;
        end else begin
            errChanQ <= errChanD;
            wdFlagQ <= wdFlagD;
            ahFlagQ <= ahFlagD;
            alFlagQ <= alFlagD;
            readyQ <= readyD;
            seenQ <= seenD;
            unreadQ <= unreadD;
        end
    end

    // Interrupt status: sticky, cleared by its own read, set wins
    always_comb begin
        irqStD = irqStRead ? cdcs_pkg::IRQ_RST : irqStQ;
        irqStD[cdcs_pkg::IRQ_WD] = irqStD[cdcs_pkg::IRQ_WD] || (wdEvent && anyErr);
        irqStD[cdcs_pkg::IRQ_AH] = irqStD[cdcs_pkg::IRQ_AH] || (ahEvent && anyErr);
        irqStD[cdcs_pkg::IRQ_AL] = irqStD[cdcs_pkg::IRQ_AL] || (alEvent && anyErr);
        irqStD[cdcs_pkg::IRQ_RDY] = irqStD[cdcs_pkg::IRQ_RDY] || readySet;
        irqD = |(irqStD & maskD);
        irqPinND = !(readyToIrqEnable && readyD);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irqStQ <= cdcs_pkg::IRQ_RST;
            irqQ <= 1'b0;
            irqPinNQ <= 1'b1;
        end else begin
            irqStQ <= irqStD;
            irqQ <= irqD;
            irqPinNQ <= irqPinND;
        end
    end

    assign regRdData = rdDataQ;
    assign refDividerChan3 = divQ;
    assign sensorFreqSelectChan3 = fselQ;
    assign refTickChan3 = divLink.refTick;
    assign irqOut = irqQ;
    assign irqPinN = irqPinNQ;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_divStore;
        regWrEn && FOUR_CHAN && regAddr == cdcs_pkg::ADDR_DIV_CH3
            |=> refDividerChan3 == $past(regWrData[cdcs_pkg::DIV_MSB:cdcs_pkg::DIV_LSB]);
    endproperty
    a_divStore: assert property (p_divStore) else $error("divider not stored");

    property p_errChan;
        anyErr ##1 (statusRead && !anyErr)
            |=> regRdData[cdcs_pkg::ST_ERRCH_MSB:cdcs_pkg::ST_ERRCH_LSB] == $past(eventChan, 2);
    endproperty
    a_errChan: assert property (p_errChan) else $error("error channel wrong");

    property p_errHold;
        wdFlagQ && !errClear |=> wdFlagQ;
    endproperty
    a_errHold: assert property (p_errHold) else $error("error latch dropped");

    property p_wdSet;
        wdEvent && chanValid(eventChan) |=> wdFlagQ && irqStQ[cdcs_pkg::IRQ_WD];
    endproperty
    a_wdSet: assert property (p_wdSet) else $error("watchdog flag not set");

    property p_ahClear;
        statusRead && !ahEvent |=> !ahFlagQ;
    endproperty
    a_ahClear: assert property (p_ahClear) else $error("amp high not cleared");

    property p_alRead;
        alFlagQ && statusRead |=> regRdData[cdcs_pkg::ST_AL] && (!alFlagQ || $past(alEvent));
    endproperty
    a_alRead: assert property (p_alRead) else $error("amp low not reported");

    property p_single;
        !sequenceModeEnable && readyToIrqEnable && convOk && convChan == singleChannelSelect
            |=> readyQ && !irqPinN;
    endproperty
    a_single: assert property (p_single) else $error("single ready missing");

    property p_seqEarly;
        sequenceModeEnable && !readyQ && !seqComplete |=> !readyQ;
    endproperty
    a_seqEarly: assert property (p_seqEarly) else $error("early sequential ready");

    property p_unread;
        convOk |=> unreadQ[$past(convChan)];
    endproperty
    a_unread: assert property (p_unread) else $error("unread flag not set");

    property p_resv;
        $past(statusRead) |-> regRdData[13:12] == 2'h0 && regRdData[8:7] == 2'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved status bits set");

    property p_readClr;
        resultRead && chanValid(resultReadChan) && !(convOk && convChan == resultReadChan)
            |=> !unreadQ[$past(resultReadChan)];
    endproperty
    a_readClr: assert property (p_readClr) else $error("unread flag kept");

    property p_twoChan;
        !FOUR_CHAN |-> unreadQ[3:2] == 2'h0 && refDividerChan3 == cdcs_pkg::DIV_RST;
    endproperty
    a_twoChan: assert property (p_twoChan) else $error("absent channel active");

    property p_irq;
        (irqStQ & maskQ) != 4'h0 |-> irqOut;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule

// *** src/cdcs_pkg.sv ***
// Constants shared by the converter status and channel 3 divider bank
package cdcs_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int MAX_CHAN = 4;
    localparam int CHAN_W = 2;

    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_DIV_CH3    = 8'h17;
    localparam logic [ADDR_W-1:0] ADDR_STATUS     = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h1c;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK   = 8'h1d;

    // Channel 3 divider register fields
    localparam int DIV_W = 10;
    localparam int DIV_LSB = 0;
    localparam int DIV_MSB = 9;
    localparam int FSEL_W = 2;
    localparam int FSEL_LSB = 12;
    localparam int FSEL_MSB = 13;
    localparam logic [DIV_W-1:0] DIV_RST = 10'h000;
    localparam logic [FSEL_W-1:0] FSEL_RST = 2'h0;

    // Converter status register fields
    localparam int ST_ERRCH_LSB = 14;
    localparam int ST_ERRCH_MSB = 15;
    localparam int ST_WD = 11;
    localparam int ST_AH = 10;
    localparam int ST_AL = 9;
    localparam int ST_RDY = 6;
    localparam int ST_UNREAD_TOP = 3;
    localparam logic [DATA_W-1:0] STATUS_RST = 16'h0000;

    // Interrupt status and mask layout
    localparam int IRQ_W = 4;
    localparam int IRQ_WD = 0;
    localparam int IRQ_AH = 1;
    localparam int IRQ_AL = 2;
    localparam int IRQ_RDY = 3;
    localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
    localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;
endpackage

// *** src/cdcs_div_if.sv ***
// Link between the register bank and the reference divider
`timescale 1ns/1ps
interface cdcs_div_if;
    logic [cdcs_pkg::DIV_W-1:0] divisor;
    logic                       refTick;
    modport ctrl (output divisor, input refTick);
    modport gen (input divisor, output refTick);
endinterface

// *** src/cdcs_ref_divider.sv ***
// Reference tick generator: one tick every divisor clocks
`timescale 1ns/1ps
module cdcs_ref_divider (
    input wire logic clk,
    input wire logic srst,
    cdcs_div_if.gen  dv
);
    logic [cdcs_pkg::DIV_W-1:0] cntQ;
    logic [cdcs_pkg::DIV_W-1:0] cntD;
    logic                       tickQ;
    logic                       tickD;

    always_comb begin
        cntD = cntQ;
        tickD = 1'b0;
        // Zero divisor is reserved: hold the generator idle
        if (dv.divisor == cdcs_pkg::DIV_RST) begin
            cntD = cdcs_pkg::DIV_RST;
        end else if (cntQ >= dv.divisor - 10'h001) begin
            cntD = cdcs_pkg::DIV_RST;
            tickD = 1'b1;
        end else begin
            cntD = cntQ + 10'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cntQ <= cdcs_pkg::DIV_RST;
            tickQ <= 1'b0;
        end else begin
            cntQ <= cntD;
            tickQ <= tickD;
        end
    end

    assign dv.refTick = tickQ;
endmodule

// *** test/cdcs_status_bank_test.sv ***
// Self-checking bench for the converter status and channel 3 divider bank
`timescale 1ns/1ps
module cdcs_status_bank_test;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  regAddr = 8'h00;
    logic [15:0] regWrData = 16'h0000;
    logic        regWrEn = 1'b0;
    logic        regRdEn = 1'b0;
    logic [15:0] regRdData;
    logic [15:0] rdData2;
    logic        sequenceModeEnable = 1'b0;
    logic [1:0]  singleChannelSelect = 2'h0;
    logic [3:0]  activeChanMask = 4'h0;
    logic        readyToIrqEnable = 1'b0;
    logic        convDone = 1'b0;
    logic [1:0]  convChan = 2'h0;
    logic        wdEvent = 1'b0;
    logic        ahEvent = 1'b0;
    logic        alEvent = 1'b0;
    logic [1:0]  eventChan = 2'h0;
    logic        resultRead = 1'b0;
    logic [1:0]  resultReadChan = 2'h0;
    logic [9:0]  refDividerChan3;
    logic [1:0]  sensorFreqSelectChan3;
    logic        refTickChan3;
    logic        irqOut;
    logic        irqPinN;
    int          numErrors = 0;
    int          totalChecks = 0;
    int          cycles = 0;
    int          seed = 32'h48f641f5;
    logic [3:0]  unr = 4'h0;
    logic [15:0] rv;
    logic [15:0] rv2;

    cdcs_status_bank #(.NUM_CHAN(4)) cdcs_status_bank_inst (
        .clk, .srst, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
        .sequenceModeEnable, .singleChannelSelect, .activeChanMask, .readyToIrqEnable,
        .convDone, .convChan, .wdEvent, .ahEvent, .alEvent, .eventChan, .resultRead,
        .resultReadChan, .refDividerChan3, .sensorFreqSelectChan3, .refTickChan3,
        .irqOut, .irqPinN);

    // Two-channel build shares every input; only its read data is watched
    cdcs_status_bank #(.NUM_CHAN(2)) cdcs_status_bank_inst2 (
        .clk, .srst, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData(rdData2),
        .sequenceModeEnable, .singleChannelSelect, .activeChanMask, .readyToIrqEnable,
        .convDone, .convChan, .wdEvent, .ahEvent, .alEvent, .eventChan, .resultRead,
        .resultReadChan, .refDividerChan3(), .sensorFreqSelectChan3(), .refTickChan3(),
        .irqOut(), .irqPinN());

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic printVerdict();
        $display("checks %0d errors %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Whole run needs well under ten thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            numErrors++;
            printVerdict();
        end
    end

    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        totalChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chkBit(input string what, input logic exp, input logic got);
        totalChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask

    function automatic logic [15:0] expSt(input logic [1:0] ch, input logic [2:0] err,
                                          input logic rdy, input logic [3:0] u);
        logic [15:0] s;
        s = 16'h0000;
        s[cdcs_pkg::ST_ERRCH_MSB:cdcs_pkg::ST_ERRCH_LSB] = ch;
        {s[cdcs_pkg::ST_WD], s[cdcs_pkg::ST_AH], s[cdcs_pkg::ST_AL]} = err;
        s[cdcs_pkg::ST_RDY] = rdy;
        for (int i = 0; i < 4; i++) begin
            s[cdcs_pkg::ST_UNREAD_TOP - i] = u[i];
        end
        return s;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        rv = regRdData;
        rv2 = rdData2;
    endtask

    task automatic ev(input logic [2:0] kind, input logic [1:0] ch);
        @(posedge clk);
        {wdEvent, ahEvent, alEvent} <= kind;
        eventChan <= ch;
        @(posedge clk);
        {wdEvent, ahEvent, alEvent} <= 3'b000;
    endtask

    task automatic conv(input logic [1:0] ch);
        @(posedge clk);
        convDone <= 1'b1;
        convChan <= ch;
        @(posedge clk);
        convDone <= 1'b0;
        unr[ch] = 1'b1;
    endtask

    task automatic rres(input logic [1:0] ch);
        @(posedge clk);
        resultRead <= 1'b1;
        resultReadChan <= ch;
        @(posedge clk);
        resultRead <= 1'b0;
        unr[ch] = 1'b0;
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    initial begin
        logic [9:0] d;
        logic [1:0] f;
        logic [3:0] m;
        int n;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        rd(cdcs_pkg::ADDR_STATUS);
        chk16("status", 16'h0000, rv);
        rd(cdcs_pkg::ADDR_DIV_CH3);
        chk16("divider reg", 16'h0000, rv);
        chkBit("irq pin", 1'b1, irqPinN);
        n = 0;
        repeat (40) begin
            @(posedge clk);
            #1;
            n += (refTickChan3 === 1'b1) ? 1 : 0;
        end
        chk16("ticks at zero", 16'h0000, 16'(n));
        wr(cdcs_pkg::ADDR_STATUS, 16'hffff);
        rd(cdcs_pkg::ADDR_STATUS);
        chk16("status write", 16'h0000, rv);
        wr(8'h42, 16'hffff);
        rd(8'h42);
        chk16("unmapped", 16'h0000, rv);
        $display("test reset done");
        for (int i = 0; i < 9; i++) begin
            d = (i == 0) ? 10'h3ff : (i == 1) ? 10'h001 : 10'($random(seed));
            d = (i > 5) ? 10'(i - 5) : d;
            d = (d == 10'h000) ? 10'h001 : d;
            f = ($random(seed) & 1) ? 2'h1 : 2'h2;
            wr(cdcs_pkg::ADDR_DIV_CH3, {2'h0, f, 2'h0, d});
            rd(cdcs_pkg::ADDR_DIV_CH3);
            chk16("divider reg", {2'h0, f, 2'h0, d}, rv);
            chk16("divider port", 16'(d), 16'(refDividerChan3));
            chk16("fsel port", 16'(f), 16'(sensorFreqSelectChan3));
            chk16("two-chan divider", 16'h0000, rv2);
            if (i > 5) begin
                n = 0;
                do begin
                    @(posedge clk);
                    #1;
                    n++;
                end while (refTickChan3 !== 1'b1 && n < 2000);
                n = 0;
                do begin
                    @(posedge clk);
                    #1;
                    n++;
                end while (refTickChan3 !== 1'b1 && n < 2000);
                chk16("tick period", 16'(d), 16'(n));
            end
        end
        $display("test divider done");
        for (int k = 0; k < 4; k++) begin
            ev(3'b100 >> (k % 3), 2'(k));
            rd(cdcs_pkg::ADDR_STATUS);
            chk16("error flag", expSt(2'(k), 3'b100 >> (k % 3), 1'b0, unr), rv);
            rd(cdcs_pkg::ADDR_STATUS);
            chk16("error cleared", expSt(2'h0, 3'b000, 1'b0, unr), rv);
        end
        ev(3'b100, 2'h1);
        ev(3'b011, 2'h2);
        rres(2'h1);
        rd(cdcs_pkg::ADDR_STATUS);
        chk16("latched errors", expSt(2'h2, 3'b111, 1'b0, unr), rv);
        ev(3'b010, 2'h3);
        rres(2'h3);
        rd(cdcs_pkg::ADDR_STATUS);
        chk16("cleared by result", expSt(2'h0, 3'b000, 1'b0, unr), rv);
        // Event straight before a status read: source channel still reported
        @(posedge clk);
        ahEvent <= 1'b1;
        eventChan <= 2'h3;
        @(posedge clk);
        ahEvent <= 1'b0;
        regAddr <= cdcs_pkg::ADDR_STATUS;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        chk16("event then read", expSt(2'h3, 3'b010, 1'b0, unr), regRdData);
        // Event in the same cycle as the clearing read must survive it
        @(posedge clk);
        regAddr <= cdcs_pkg::ADDR_STATUS;
        regRdEn <= 1'b1;
        wdEvent <= 1'b1;
        eventChan <= 2'h1;
        @(posedge clk);
        regRdEn <= 1'b0;
        wdEvent <= 1'b0;
        rd(cdcs_pkg::ADDR_STATUS);
        chk16("event in clear", expSt(2'h1, 3'b100, 1'b0, unr), rv);
        $display("test errors done");
        rd(cdcs_pkg::ADDR_IRQ_STATUS);
        chk16("irq status", 16'h0007, rv);
        rd(cdcs_pkg::ADDR_IRQ_STATUS);
        chk16("irq status clear", 16'h0000, rv);
        wr(cdcs_pkg::ADDR_IRQ_MASK, 16'h0002);
        rd(cdcs_pkg::ADDR_IRQ_MASK);
        chk16("irq mask", 16'h0002, rv);
        ev(3'b100, 2'h0);
        settle();
        chkBit("irq masked", 1'b0, irqOut);
        ev(3'b010, 2'h0);
        settle();
        chkBit("irq raised", 1'b1, irqOut);
        rd(cdcs_pkg::ADDR_IRQ_STATUS);
        chk16("irq status", 16'h0003, rv);
        settle();
        chkBit("irq cleared", 1'b0, irqOut);
        rd(cdcs_pkg::ADDR_STATUS);
        $display("test interrupt done");
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            singleChannelSelect <= 2'(s);
            readyToIrqEnable <= 1'b1;
            conv(2'(s + 1));
            rd(cdcs_pkg::ADDR_STATUS);
            chk16("other channel", expSt(2'h0, 3'b000, 1'b0, unr), rv);
            conv(2'(s));
            settle();
            chkBit("irq pin ready", 1'b0, irqPinN);
            rd(cdcs_pkg::ADDR_STATUS);
            chk16("ready single", expSt(2'h0, 3'b000, 1'b1, unr), rv);
            if (s == 3) chk16("two-chan status", 16'h0008, rv2);
            settle();
            chkBit("irq pin idle", 1'b1, irqPinN);
            rres(2'(s + 1));
            rres(2'(s));
            rd(cdcs_pkg::ADDR_STATUS);
            chk16("unread cleared", expSt(2'h0, 3'b000, 1'b0, unr), rv);
        end
        @(posedge clk);
        readyToIrqEnable <= 1'b0;
        singleChannelSelect <= 2'h2;
        conv(2'h2);
        settle();
        chkBit("irq pin off", 1'b1, irqPinN);
        rd(cdcs_pkg::ADDR_STATUS);
        chk16("ready off", expSt(2'h0, 3'b000, 1'b0, unr), rv);
        rd(cdcs_pkg::ADDR_IRQ_STATUS);
        chk16("irq ready bit", 16'h0008, rv);
        $display("test single done");
        // Second reset in mid-run also restarts sequence tracking
        @(posedge clk);
        srst <= 1'b1;
        sequenceModeEnable <= 1'b1;
        readyToIrqEnable <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        unr = 4'h0;
        rd(cdcs_pkg::ADDR_IRQ_MASK);
        chk16("mask after reset", 16'h0000, rv);
        for (int r = 0; r < 4; r++) begin
            m = (r == 0) ? 4'hf : 4'($random(seed));
            m = (m == 4'h0) ? 4'h5 : m;
            @(posedge clk);
            activeChanMask <= m;
            if (!m[3]) conv(2'h3);
            for (int ch = 0; ch < 4; ch++) begin
                if (m[ch]) begin
                    conv(2'(ch));
                    rd(cdcs_pkg::ADDR_STATUS);
                    chk16("sequence ready", expSt(2'h0, 3'b000, (m >> (ch + 1)) == 4'h0, unr), rv);
                end
            end
            for (int ch = 0; ch < 4; ch++) rres(2'(ch));
        end
        $display("test sequence done");
        printVerdict();
    end
endmodule
